//--- suspend_wake_pkg.sv
`default_nettype none
package suspend_wake_pkg;

  // wake-up cycle counts, programmable 1 to 1024
  localparam int unsigned CNT_W            = 11;
  localparam logic [10:0] CNT_MIN          = 11'h001;
  localparam logic [10:0] CNT_MAX          = 11'h400;
  localparam logic [10:0] RELEASE_DEFAULT  = 11'h004;
  localparam logic [10:0] UNLOCK_DEFAULT   = 11'h005;

  // system clock and suspend glitch filter
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned FILTER_NS        = 100;
  localparam int unsigned FILTER_CYCLES    =
    (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // nominal internal oscillator rate, not a precise figure
  localparam int unsigned OSC_NOMINAL_MHZ  = 50;

  typedef enum logic {
    WAKE_SEL_INTERNAL = 1'b0,
    WAKE_SEL_STARTUP  = 1'b1
  } wake_clk_sel_t;

  typedef enum logic [1:0] {
    STARTUP_SEL_CONFIG_CLK = 2'h0,
    STARTUP_SEL_TEST_CLK   = 2'h1,
    STARTUP_SEL_FABRIC_CLK = 2'h2
  } startup_clk_sel_t;

  typedef enum logic [2:0] {
    ST_CONFIG     = 3'h0,
    ST_ACTIVE     = 3'h1,
    ST_SUSPEND    = 3'h2,
    ST_WAIT_AWAKE = 3'h3,
    ST_WAKE       = 3'h4
  } seq_state_t;

endpackage
`default_nettype wire

//--- pin_sync_filter.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync_filter #(
  parameter int unsigned FILTER_CYCLES = 0,
  parameter logic        RESET_VAL     = 1'b0
) (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_pin,
  input  wire logic i_filter_en,
  output logic      o_level
);

  typedef struct packed {
    logic       meta;
    logic       sync;
    logic       level;
    logic [7:0] cnt;
  } filt_t;

  filt_t r_reg;
  filt_t r_next;

  // the filter only looks at the second stage, never at the first
  always_comb begin
    r_next      = r_reg;
    r_next.meta = i_pin;
    r_next.sync = r_reg.meta;
    if (!i_filter_en || FILTER_CYCLES == 0) begin
      r_next.level = r_reg.sync;
      r_next.cnt   = '0;
    end else if (r_reg.sync == r_reg.level) begin
      r_next.cnt = '0;
    end else if (r_reg.cnt == 8'(FILTER_CYCLES - 1)) begin
      r_next.level = r_reg.sync;
      r_next.cnt   = '0;
    end else begin
      r_next.cnt = r_reg.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '{meta: RESET_VAL, sync: RESET_VAL, level: RESET_VAL,
                 cnt: 8'h00};
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_level = r_reg.level;

endmodule
`default_nettype wire

//--- suspend_wake_sequencer.sv
// Notes on behaviour
// R1 - wake sequence runs from one selected clock, steps counted in its cycles
// R2 - wake select picks internal oscillator or the startup clock select path
// R3 - startup path defaults to the configuration clock pin
// R4 - internal oscillator is switched off throughout suspend
// R5 - internal oscillator is about 50 MHz, so timing is approximate
// R6 - configuration clock only usable in slave mode with persistent pins
// R7 - test clock must keep toggling for the wake to complete
// R8 - fabric wake clock must come from unclocked logic only
// R9 - outputs return to normal after release count wake cycles, 1..1024
// R10 - write lock lifts after unlock count wake cycles, 1..1024
// R11 - optional global reset applied before the write lock lifts
// R12 - program outputs to release before the write lock lifts
// R13 - test, done and reprogram pins keep working during suspend
// R14 - request low in normal operation, high forces suspend
// R15 - with feature disabled the request input is ignored
// R16 - high-to-low request starts the wake; low means running
// R17 - selectable glitch filter on request; bypass is faster
// R18 - configuration completes, then suspend entered at once if requested
// R19 - awake status low in suspend, high while active
// R20 - entering suspend write-locks every clocked element
// R21 - suspend left only once the awake line is really high
// R22 - wake counters cleared on entry, advance on wake clock edges
`timescale 1ns/1ns
`default_nettype none
module suspend_wake_sequencer
  import suspend_wake_pkg::*;
(
  input  wire logic                                i_mclk,
  input  wire logic                                i_rst,
  input  wire logic                                i_suspend_en,
  input  wire logic                                i_filter_en,
  input  wire logic                                i_suspend,
  input  wire logic                                i_config_done,
  input  wire logic                                i_reprogram_n,
  input  wire suspend_wake_pkg::wake_clk_sel_t     i_wake_clock_select,
  input  wire suspend_wake_pkg::startup_clk_sel_t  i_startup_clock_select,
  input  wire logic                                i_osc_clk,
  input  wire logic                                i_config_clk,
  input  wire logic                                i_test_clk,
  input  wire logic                                i_fabric_clk,
  input  wire logic [suspend_wake_pkg::CNT_W-1:0]  i_output_release_count,
  input  wire logic [suspend_wake_pkg::CNT_W-1:0]  i_write_unlock_count,
  input  wire logic                                i_wake_global_reset_en,
  input  wire logic                                i_awake,
  output logic                                     o_awake,
  output logic                                     o_awake_o,
  output logic                                     o_awake_oe_n,
  output logic                                     o_osc_en,
  output logic                                     o_outputs_suspended,
  output logic                                     o_write_lock,
  output logic                                     o_global_reset
);

  import suspend_wake_pkg::*;

  typedef struct packed {
    seq_state_t        state;
    logic              awake;
    logic              drive_low;
    logic              osc_en;
    logic              out_susp;
    logic              wlock;
    logic              gsr;
    logic              gsr_done;
    logic              clk_prev;
    logic [CNT_W-1:0]  rel_cnt;
    logic [CNT_W-1:0]  unl_cnt;
  } seq_t;

  seq_t r_reg;
  seq_t r_next;

  logic suspend_lvl;
  logic reprogram_lvl_n;
  logic awake_lvl;
  logic osc_lvl;
  logic config_clk_lvl;
  logic test_clk_lvl;
  logic fabric_clk_lvl;
  logic wake_clk;
  logic wake_edge;
  logic suspend_req;
  logic [CNT_W-1:0] rel_target;
  logic [CNT_W-1:0] unl_target;

  // every clock, request, reprogram and awake pin passes three flops; only the request has the filter
  pin_sync_filter #(
    .FILTER_CYCLES (FILTER_CYCLES),
    .RESET_VAL     (1'b0)
  ) u_sync_suspend (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_pin       (i_suspend),
    .i_filter_en (i_filter_en), // R17
    .o_level     (suspend_lvl)
  );

  pin_sync_filter #(
    .FILTER_CYCLES (0),
    .RESET_VAL     (1'b1)
  ) u_sync_reprogram (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_pin       (i_reprogram_n),
    .i_filter_en (1'b0),
    .o_level     (reprogram_lvl_n)
  );

  pin_sync_filter #(
    .FILTER_CYCLES (0),
    .RESET_VAL     (1'b0)
  ) u_sync_awake (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_pin       (i_awake),
    .i_filter_en (1'b0),
    .o_level     (awake_lvl)
  );

  pin_sync_filter #(
    .FILTER_CYCLES (0),
    .RESET_VAL     (1'b0)
  ) u_sync_osc (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_pin       (i_osc_clk),
    .i_filter_en (1'b0),
    .o_level     (osc_lvl)
  );

  pin_sync_filter #(
    .FILTER_CYCLES (0),
    .RESET_VAL     (1'b0)
  ) u_sync_config_clk (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_pin       (i_config_clk),
    .i_filter_en (1'b0),
    .o_level     (config_clk_lvl)
  );

  pin_sync_filter #(
    .FILTER_CYCLES (0),
    .RESET_VAL     (1'b0)
  ) u_sync_test_clk (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_pin       (i_test_clk),
    .i_filter_en (1'b0),
    .o_level     (test_clk_lvl)
  );

  pin_sync_filter #(
    .FILTER_CYCLES (0),
    .RESET_VAL     (1'b0)
  ) u_sync_fabric_clk (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_pin       (i_fabric_clk),
    .i_filter_en (1'b0),
    .o_level     (fabric_clk_lvl)
  );

  // counts outside 1..1024 are pulled to the nearest legal value
  function automatic logic [CNT_W-1:0] clamp_count(
    input logic [CNT_W-1:0] v
  );
    logic [CNT_W-1:0] c;
    c = v;
    if (v < CNT_MIN) begin
      c = CNT_MIN;
    end else if (v > CNT_MAX) begin
      c = CNT_MAX;
    end
    return c;
  endfunction

  function automatic seq_t enter_suspend(input seq_t s);
    seq_t t;
    t           = s;
    t.state     = ST_SUSPEND;
    t.awake     = 1'b0;
    t.drive_low = 1'b1;
    t.osc_en    = 1'b0; // R4
    t.out_susp  = 1'b1;
    t.wlock     = 1'b1; // R20
    t.gsr       = 1'b0;
    t.gsr_done  = 1'b0;
    t.rel_cnt   = '0; // R22
    t.unl_cnt   = '0; // R22
    return t;
  endfunction

  // one wake clock for the whole sequence; selection is meant to be static,
  // a live change can produce one spurious edge
  always_comb begin
    wake_clk = osc_lvl; // R5
    if (i_wake_clock_select == WAKE_SEL_STARTUP) begin // R2
      unique case (i_startup_clock_select)
        STARTUP_SEL_CONFIG_CLK: wake_clk = config_clk_lvl; // R3
        STARTUP_SEL_TEST_CLK:   wake_clk = test_clk_lvl;
        STARTUP_SEL_FABRIC_CLK: wake_clk = fabric_clk_lvl;
        default:                wake_clk = config_clk_lvl; // R3
      endcase
    end
  end

  assign wake_edge   = wake_clk & ~r_reg.clk_prev; // R1
  assign suspend_req = i_suspend_en & suspend_lvl; // R15 R14
  assign rel_target  = clamp_count(i_output_release_count);
  assign unl_target  = clamp_count(i_write_unlock_count);

  always_comb begin
    r_next          = r_reg;
    r_next.gsr      = 1'b0;
    r_next.clk_prev = wake_clk;
    if (!reprogram_lvl_n) begin // R13
      r_next          = r_reg;
      r_next.state    = ST_CONFIG;
      r_next.awake    = 1'b0;
      r_next.drive_low = 1'b0;
      r_next.osc_en   = 1'b1;
      r_next.out_susp = 1'b1;
      r_next.wlock    = 1'b1;
      r_next.gsr      = 1'b0;
      r_next.gsr_done = 1'b0;
      r_next.clk_prev = wake_clk;
      r_next.rel_cnt  = '0;
      r_next.unl_cnt  = '0;
    end else begin
      unique case (r_reg.state)
        ST_CONFIG: begin
          // the request never holds up configuration itself
          if (i_config_done) begin
            if (suspend_req) begin // R18
              r_next = enter_suspend(r_reg);
              r_next.clk_prev = wake_clk;
            end else begin
              r_next.state    = ST_ACTIVE;
              r_next.awake    = 1'b1;
              r_next.out_susp = 1'b0;
              r_next.wlock    = 1'b0;
            end
          end
        end
        ST_ACTIVE: begin
          if (suspend_req) begin // R14
            r_next = enter_suspend(r_reg);
            r_next.clk_prev = wake_clk;
          end
        end
        ST_SUSPEND: begin
          if (!suspend_req) begin // R16
            r_next.state     = ST_WAIT_AWAKE;
            r_next.drive_low = 1'b0;
            r_next.osc_en    = 1'b1;
          end
        end
        ST_WAIT_AWAKE: begin
          // an outside controller may hold the line low to delay us
          if (suspend_req) begin
            r_next = enter_suspend(r_reg);
            r_next.clk_prev = wake_clk;
          end else if (awake_lvl) begin // R21
            r_next.state = ST_WAKE;
            r_next.awake = 1'b1; // R19
          end
        end
        ST_WAKE: begin
          if (suspend_req) begin
            r_next = enter_suspend(r_reg);
            r_next.clk_prev = wake_clk;
          end else begin
            if (wake_edge) begin // R22
              if (r_reg.rel_cnt < CNT_MAX) begin
                r_next.rel_cnt = r_reg.rel_cnt + 11'h001;
              end
              if (r_reg.unl_cnt < CNT_MAX) begin
                r_next.unl_cnt = r_reg.unl_cnt + 11'h001;
              end
            end
            if (r_reg.rel_cnt >= rel_target) begin // R9
              r_next.out_susp = 1'b0;
            end
            if (r_reg.unl_cnt >= unl_target && r_reg.wlock) begin // R10
              // reset pulse first, lock lifts on the following cycle
              if (i_wake_global_reset_en && !r_reg.gsr_done) begin // R11
                r_next.gsr      = 1'b1;
                r_next.gsr_done = 1'b1;
              end else begin
                r_next.wlock = 1'b0;
              end
            end
            if (!r_reg.out_susp && !r_reg.wlock) begin
              r_next.state = ST_ACTIVE;
            end
          end
        end
        default: begin
          r_next = enter_suspend(r_reg);
          r_next.clk_prev = wake_clk;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r_reg <= '{state: ST_CONFIG, awake: 1'b0, drive_low: 1'b0,
                 osc_en: 1'b1, out_susp: 1'b1, wlock: 1'b1, gsr: 1'b0,
                 gsr_done: 1'b0, clk_prev: 1'b0, rel_cnt: 11'h000,
                 unl_cnt: 11'h000};
    end else begin
      r_reg <= r_next;
    end
  end

  // open-drain awake line: only ever pulled low, never driven high
  assign o_awake_o           = 1'b0;
  assign o_awake_oe_n        = ~r_reg.drive_low; // R19
  assign o_awake             = r_reg.awake; // R19
  assign o_osc_en            = r_reg.osc_en;
  assign o_outputs_suspended = r_reg.out_susp;
  assign o_write_lock        = r_reg.wlock;
  assign o_global_reset      = r_reg.gsr;

endmodule
`default_nettype wire

//--- suspend_wake_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module suspend_wake_asserts (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_suspend_en,
  input wire logic i_filter_en,
  input wire logic i_suspend,
  input wire logic i_wake_global_reset_en,
  input wire logic i_awake,
  input wire logic o_awake,
  input wire logic o_awake_oe_n,
  input wire logic o_osc_en,
  input wire logic o_outputs_suspended,
  input wire logic o_write_lock,
  input wire logic o_global_reset
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [3:0] hi_reg;
  // run length of the raw request; saturates so a long hold never wraps
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      hi_reg <= 4'h0;
    else if (!i_suspend)
      hi_reg <= 4'h0;
    else if (hi_reg != 4'hf)
      hi_reg <= hi_reg + 4'h1;
  property p_sleep; !o_awake_oe_n |-> !o_osc_en && !o_awake; endproperty
  a_sleep: assert property (p_sleep) else $error("awake in suspend");
  property p_entry;
    $fell(o_awake) && !o_awake_oe_n |-> o_outputs_suspended && o_write_lock;
  endproperty
  a_entry: assert property (p_entry) else $error("entry left unlocked");
  property p_lock; !o_write_lock |-> o_awake; endproperty
  a_lock: assert property (p_lock) else $error("unlocked while asleep");
  property p_rel; !o_outputs_suspended |-> o_awake; endproperty
  a_rel: assert property (p_rel) else $error("outputs live asleep");
  property p_pulse;
    o_global_reset |-> o_write_lock ##1 (!o_global_reset && !o_write_lock);
  endproperty
  a_pulse: assert property (p_pulse) else $error("bad reset pulse");
  property p_gfirst;
    $fell(o_write_lock) && $past(o_awake) && i_wake_global_reset_en
      |-> $past(o_global_reset);
  endproperty
  a_gfirst: assert property (p_gfirst) else $error("no reset first");
  property p_line; $rose(o_awake) |-> $past(i_awake, 2); endproperty
  a_line: assert property (p_line) else $error("woke with line low");
  property p_wake;
    !i_filter_en && i_suspend_en && !o_awake_oe_n && $fell(i_suspend)
      |-> ##[1:4] o_awake_oe_n;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not started");
  property p_off; !i_suspend_en && o_awake |=> o_awake; endproperty
  a_off: assert property (p_off) else $error("request not ignored");
  property p_filt;
    $fell(o_awake_oe_n) && i_filter_en |-> hi_reg >= 4'h5;
  endproperty
  a_filt: assert property (p_filt) else $error("glitch passed");
  c_gsr: cover property (o_global_reset);
  c_rel: cover property ($fell(o_outputs_suspended));
  c_filt: cover property ($fell(o_awake_oe_n) && i_filter_en);
endmodule
bind suspend_wake_sequencer suspend_wake_asserts u_chk (
  .i_mclk, .i_rst, .i_suspend_en, .i_filter_en, .i_suspend,
  .i_wake_global_reset_en, .i_awake, .o_awake, .o_awake_oe_n, .o_osc_en,
  .o_outputs_suspended, .o_write_lock, .o_global_reset);
`default_nettype wire

//--- sys_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module sys_ctrl_model (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_req,
  input  wire logic i_hold,
  input  wire logic i_run,
  input  wire logic i_awake_o,
  input  wire logic i_awake_oe_n,
  output logic      o_suspend,
  output logic      o_awake_line,
  output logic      o_wake_clk
);
  logic [1:0] div_reg;
  // open drain with pull-up; holding low delays the wake
  assign o_awake_line = (i_awake_oe_n ? 1'b1 : i_awake_o) & !i_hold;
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      o_suspend <= 1'b0;
    else
      o_suspend <= i_req;
  // clock stands low outside a wake, toggles for the whole wake
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst || !i_run) begin
      div_reg <= 2'h0;
      o_wake_clk <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      if (div_reg == 2'h3)
        o_wake_clk <= !o_wake_clk;
    end
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import suspend_wake_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic en = 1'b1, filt = 1'b0, done = 1'b0, prog_n = 1'b1, gsr = 1'b1;
  logic req = 1'b0, hold = 1'b0, run = 1'b0;
  wake_clk_sel_t wsel = WAKE_SEL_INTERNAL;
  startup_clk_sel_t ssel = STARTUP_SEL_CONFIG_CLK;
  logic [10:0] rel = 11'h001, unl = 11'h002;
  wire logic susp, line, wclk, awake, aw_o, oe_n, osc_en, outs, lock, grst;
  wire logic st = (wsel == WAKE_SEL_STARTUP);
  wire logic osc = wclk & osc_en & !st;
  // slave-mode host supplies the configuration clock; code 3 acts as code 0
  wire logic cfg = wclk & st & (ssel[0] == ssel[1]);
  wire logic tck = wclk & st & (ssel == STARTUP_SEL_TEST_CLK);
  wire logic fab = wclk & st & (ssel == STARTUP_SEL_FABRIC_CLK);
  int fail_count = 0, comparisons = 0;
  wake_clk_sel_t ws[5] = '{WAKE_SEL_INTERNAL, WAKE_SEL_STARTUP,
    WAKE_SEL_STARTUP, WAKE_SEL_STARTUP, WAKE_SEL_STARTUP};
  startup_clk_sel_t ss[5] = '{STARTUP_SEL_CONFIG_CLK, STARTUP_SEL_CONFIG_CLK,
    STARTUP_SEL_TEST_CLK, STARTUP_SEL_FABRIC_CLK, startup_clk_sel_t'(2'h3)};
  logic [10:0] rc[5] = '{11'h001, RELEASE_DEFAULT, CNT_MAX, 11'h000, 11'h003};
  logic [10:0] re[5] = '{11'h001, RELEASE_DEFAULT, CNT_MAX, CNT_MIN, 11'h003};
  // release count never above unlock count, so outputs come back first
  logic [10:0] uc[5] = '{11'h002, UNLOCK_DEFAULT, 11'h7ff, 11'h002, 11'h004};
  logic [10:0] ue[5] = '{11'h002, UNLOCK_DEFAULT, CNT_MAX, 11'h002, 11'h004};
  always #10 i_mclk = ~i_mclk;
  suspend_wake_sequencer uut (.i_mclk, .i_rst, .i_suspend_en(en),
    .i_filter_en(filt), .i_suspend(susp), .i_config_done(done),
    .i_reprogram_n(prog_n), .i_wake_clock_select(wsel),
    .i_startup_clock_select(ssel), .i_osc_clk(osc), .i_config_clk(cfg),
    .i_test_clk(tck), .i_fabric_clk(fab), .i_output_release_count(rel),
    .i_write_unlock_count(unl), .i_wake_global_reset_en(gsr),
    .i_awake(line), .o_awake(awake), .o_awake_o(aw_o), .o_awake_oe_n(oe_n),
    .o_osc_en(osc_en), .o_outputs_suspended(outs), .o_write_lock(lock),
    .o_global_reset(grst));
  sys_ctrl_model ctl (.i_mclk, .i_rst, .i_req(req), .i_hold(hold),
    .i_run(run), .i_awake_o(aw_o), .i_awake_oe_n(oe_n), .o_suspend(susp),
    .o_awake_line(line), .o_wake_clk(wclk));
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // wake edges are counted only once awake is high, as the counters are
  task automatic wake(input logic [10:0] erel, input logic [10:0] eunl);
    int n, nr, nu;
    logic q, g;
    n = 0; nr = 0; nu = 0; q = 1'b0; g = 1'b0;
    hold <= 1'b1;
    req <= 1'b0;
    settle(30);
    chk({oe_n, osc_en, awake}, 11'h006);
    hold <= 1'b0;
    while (awake !== 1'b1 && n < 40) begin
      settle(1);
      n++;
    end
    chk(awake, 11'h001);
    run <= 1'b1;
    n = 0;
    for (int i = 0; i < 12000 && (outs | lock); i++) begin
      settle(1);
      if (wclk && !q) n++;
      q = wclk;
      if (outs) nr = n;
      if (lock) nu = n;
      g |= grst;
    end
    run <= 1'b0;
    chk(nr[10:0], erel);
    chk(nu[10:0], eunl);
    chk(g, gsr);
    settle(3);
    chk({awake, outs, lock}, 11'h004);
    $display("wake test done");
  endtask
  task automatic enter;
    if (filt) begin
      req <= 1'b1;
      settle(3);
      req <= 1'b0;
      settle(15);
      chk(oe_n, 11'h001);
    end
    req <= 1'b1;
    settle(14);
    chk({oe_n, osc_en, outs, lock, awake}, 11'h006);
    $display("suspend test done");
  endtask
  initial begin
    settle(6);
    i_rst <= 1'b0;
    req <= 1'b1;
    settle(10);
    done <= 1'b1;
    settle(20);
    chk({oe_n, osc_en, awake}, 11'h000);
    $display("config test done");
    for (int k = 0; k < 5; k++) begin
      wsel <= ws[k];
      ssel <= ss[k];
      rel <= rc[k];
      unl <= uc[k];
      gsr <= !k[0];
      filt <= (k >= 2);
      wake(re[k], ue[k]);
      if (k < 4) enter;
    end
    prog_n <= 1'b0;
    settle(6);
    chk({awake, oe_n, outs, lock}, 11'h007);
    prog_n <= 1'b1;
    settle(6);
    chk({awake, outs, lock}, 11'h004);
    $display("reprogram test done");
    en <= 1'b0;
    settle(2);
    req <= 1'b1;
    settle(20);
    chk({awake, oe_n, aw_o}, 11'h006);
    $display("disable test done");
    end_of_test;
  end
  initial begin
    settle(60000);
    fail_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
